/* hdl/level_ctrl_pkg.sv */
// Package: register map, field layout, reset values and time constants
// for the audio level control and record-path configuration block.
// Assumes a Wishbone classic slave with 32-bit data, one register per word.
package level_ctrl_pkg;

  // ==========================================================================
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_HOLD_CHSEL = 8'h21;
  localparam logic [7:0] IDX_ATK_DCY    = 8'h22;
  localparam logic [7:0] IDX_NGATE      = 8'h23;
  localparam logic [7:0] IDX_GAIN_FLOOR = 8'h24;
  localparam logic [7:0] IDX_POL_GAIN   = 8'h25;
  localparam logic [7:0] IDX_MIC_CTRL   = 8'h28;
  localparam logic [7:0] IDX_CLK_SHIFT  = 8'h29;
  localparam logic [7:0] IDX_MUTE_STEP  = 8'h2A;
  localparam logic [7:0] IDX_DEC2_CTRL  = 8'h2B;
  localparam logic [7:0] IDX_DEC2_RATE  = 8'h2C;
  localparam logic [7:0] IDX_STATUS     = 8'h30;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_HOLD_CHSEL = 8'h00;
  localparam logic [7:0] RST_ATK_DCY    = 8'h32;
  localparam logic [7:0] RST_NGATE      = 8'h00;
  localparam logic [7:0] RST_GAIN_FLOOR = 8'h02;
  localparam logic [7:0] RST_POL_GAIN   = 8'h00;
  localparam logic [7:0] RST_MIC_CTRL   = 8'h40;
  localparam logic [7:0] RST_CLK_SHIFT  = 8'h01;
  localparam logic [7:0] RST_MUTE_STEP  = 8'h0A;
  localparam logic [7:0] RST_DEC2_CTRL  = 8'h00;
  localparam logic [7:0] RST_DEC2_RATE  = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int HOLD_LSB = 0;
  localparam int CHSEL_LSB = 5;
  localparam int ATK_LSB = 0;
  localparam int DCY_LSB = 4;
  localparam int NG_EN_BIT = 0;
  localparam int NG_ACT_LSB = 1;
  localparam int NG_TH_LSB = 3;
  localparam int FLOOR_LSB = 0;
  localparam int LINV_BIT = 0;
  localparam int RINV_BIT = 1;
  localparam int DGAIN_BIT = 2;
  localparam int DECG_LSB = 4;
  localparam int MIX_BIT = 7;
  localparam int D1CH_LSB = 0;
  localparam int RESYNC_BIT = 2;
  localparam int DMIC_BIT = 3;
  localparam int LRCLK_EN_BIT = 0;
  localparam int LRCLK_SEL_BIT = 1;
  localparam int SHIFT_LSB = 2;
  localparam int SMUTE_BIT = 4;
  localparam int FIX6M_BIT = 5;
  localparam int DSM_SEL_BIT = 7;
  localparam int D2EN_BIT = 0;
  localparam int MCLK2_BIT = 1;
  localparam int D2CH_LSB = 2;
  localparam int D2SWAP_BIT = 4;
  localparam int D2SR_LSB = 0;
  localparam int DACINV_BIT = 5;

  // ==========================================================================
  // Codes and limits
  localparam logic [3:0] TIME_SAT_CODE  = 4'hA;
  localparam logic [1:0] NG_ACT_MUTE    = 2'h1;
  localparam logic [1:0] NG_ACT_RSVD    = 2'h3;
  localparam logic [1:0] CHSEL_OFF      = 2'h0;
  localparam logic [3:0] SHIFT_CODE0    = 4'h8;
  localparam logic [3:0] SHIFT_CODE1    = 4'h7;
  localparam logic [3:0] SHIFT_CODE23   = 4'h9;

  // ==========================================================================
  // Times (in microseconds) and cycle counts at the system clock
  localparam int CLK_HZ        = 40_000_000;
  localparam int HOLD_BASE_US  = 2670;
  localparam int ATK_BASE_US   = 6000;
  localparam int DCY_BASE_US   = 24000;
  localparam int SAMPLE_US     = 125;
  localparam longint US_DEN    = 1_000_000;
  localparam int SAMPLE_CYC    = int'((longint'(SAMPLE_US) * CLK_HZ) / US_DEN);
  localparam int HOLD_BASE_CYC = int'((longint'(HOLD_BASE_US) * CLK_HZ + US_DEN - 1) / US_DEN);
  localparam int ATK_BASE_CYC  = int'((longint'(ATK_BASE_US) * CLK_HZ + US_DEN - 1) / US_DEN);
  localparam int DCY_BASE_CYC  = int'((longint'(DCY_BASE_US) * CLK_HZ + US_DEN - 1) / US_DEN);

endpackage : level_ctrl_pkg

/* hdl/level_ctrl_regs.sv */
// Register bank and setting decode for the audio level controller,
// noise gate, converter gain options and record-path configuration.
// Assumes a classic Wishbone master on clk_sys and an audio front end
// that reads the decoded settings; sample boundaries are timed locally.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps

module level_ctrl_regs (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             level_ctrl_left_on,
  output logic             level_ctrl_right_on,
  output logic      [31:0] gain_hold_cycles,
  output logic      [31:0] attack_cycles,
  output logic      [31:0] decay_cycles,
  output logic             noise_gate_enable,
  output logic             noise_gate_hold_gain,
  output logic             noise_gate_mute,
  output logic      [4:0]  noise_gate_threshold,
  output logic      [2:0]  gain_floor,
  output logic             left_output_invert,
  output logic             right_output_invert,
  output logic             dac_gain_double,
  output logic      [3:0]  decimator_gain_mult,
  output logic             stereo_average_mix,
  output logic      [1:0]  first_decimator_channel_enables,
  output logic             mic_resync_scan_clk,
  output logic             digital_mic_select,
  output logic             low_rate_clock_enable,
  output logic             low_rate_clock_select,
  output logic             analog_fixed_six_mhz_clock,
  output logic      [3:0]  decimator_shift,
  output logic             soft_mute_enable,
  output logic      [7:0]  soft_mute_step,
  output logic             debug_dsm_right_select,
  output logic             second_decimator_enable,
  output logic             second_codec_master_clock_gate,
  output logic      [1:0]  second_decimator_channel_enables,
  output logic             second_decimator_channel_swap,
  output logic      [4:0]  second_decimator_sample_rate,
  output logic             dac_clock_invert
);
  import level_ctrl_pkg::*;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [7:0] hold_chsel;
    logic [7:0] atk_dcy;
    logic [7:0] ngate;
    logic [7:0] floor;
    logic [7:0] pol_gain;
    logic [7:0] mic;
    logic [7:0] clk_shift;
    logic [7:0] mute_step;
    logic [7:0] dec2_ctrl;
    logic [7:0] dec2_rate;
  } bank_t;

  typedef struct packed {
    bank_t       shadow;   // software view
    bank_t       active;   // applied at sample boundary
    logic        pending;
    logic [15:0] smp_cnt;
    logic [31:0] dat;
    logic        ack;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  localparam bank_t BANK_RST = '{RST_HOLD_CHSEL, RST_ATK_DCY, RST_NGATE, RST_GAIN_FLOOR,
                                 RST_POL_GAIN, RST_MIC_CTRL, RST_CLK_SHIFT, RST_MUTE_STEP,
                                 RST_DEC2_CTRL, RST_DEC2_RATE};
  localparam logic [15:0] SMP_LAST = 16'(SAMPLE_CYC - 1);

  // ==========================================================================
  // Decode helpers
  // Doubling time, saturating at code 10 for attack and decay only; code zero of hold means no wait.
  function automatic logic [31:0] doubled(input logic [3:0] code, input int base,
                                          input logic zero_none);
    logic [3:0] c;
    c = (code >= TIME_SAT_CODE) ? TIME_SAT_CODE : code;
    if (zero_none) begin
      doubled = (code == 4'h0) ? 32'h0 : 32'(base) << (code - 4'h1);
    end else begin
      doubled = 32'(base) << c;
    end
  endfunction : doubled

  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                         input logic sel0);
    wr_byte = sel0 ? d[7:0] : old;
  endfunction : wr_byte

  // ==========================================================================
  // Bus and apply logic
  logic        hit;
  logic [7:0]  idx;
  always_comb begin
    st_nxt = st_r;
    idx    = wb_adr_i[9:2];
    hit    = wb_cyc_i && wb_stb_i && !st_r.ack;
    st_nxt.ack = hit;
    st_nxt.smp_cnt = (st_r.smp_cnt == SMP_LAST) ? 16'h0 : st_r.smp_cnt + 16'h1;
    // Software writes land in the shadow copy; front end sees them later
    if (hit && wb_we_i) begin
      st_nxt.pending = 1'b1;
      unique case (idx)
        IDX_HOLD_CHSEL: st_nxt.shadow.hold_chsel = wr_byte(st_r.shadow.hold_chsel, wb_dat_i,
                                                           wb_sel_i[0]);
        IDX_ATK_DCY:    st_nxt.shadow.atk_dcy   = wr_byte(st_r.shadow.atk_dcy, wb_dat_i,
                                                          wb_sel_i[0]);
        IDX_NGATE:      st_nxt.shadow.ngate     = wr_byte(st_r.shadow.ngate, wb_dat_i,
                                                          wb_sel_i[0]);
        IDX_GAIN_FLOOR: st_nxt.shadow.floor     = wr_byte(st_r.shadow.floor, wb_dat_i,
                                                          wb_sel_i[0]);
        IDX_POL_GAIN:   st_nxt.shadow.pol_gain  = wr_byte(st_r.shadow.pol_gain, wb_dat_i,
                                                          wb_sel_i[0]);
        IDX_MIC_CTRL:   st_nxt.shadow.mic       = wr_byte(st_r.shadow.mic, wb_dat_i,
                                                          wb_sel_i[0]);
        IDX_CLK_SHIFT:  st_nxt.shadow.clk_shift = wr_byte(st_r.shadow.clk_shift, wb_dat_i,
                                                          wb_sel_i[0]);
        IDX_MUTE_STEP:  st_nxt.shadow.mute_step = wr_byte(st_r.shadow.mute_step, wb_dat_i,
                                                          wb_sel_i[0]);
        IDX_DEC2_CTRL:  st_nxt.shadow.dec2_ctrl = wr_byte(st_r.shadow.dec2_ctrl, wb_dat_i,
                                                          wb_sel_i[0]);
        IDX_DEC2_RATE:  st_nxt.shadow.dec2_rate = wr_byte(st_r.shadow.dec2_rate, wb_dat_i,
                                                          wb_sel_i[0]);
        default:        st_nxt.pending = st_r.pending;
      endcase
    end
    // Copy at the boundary; a write in that same cycle stays pending
    if (st_r.smp_cnt == SMP_LAST && st_r.pending) begin
      st_nxt.active = st_r.shadow;
      if (!(hit && wb_we_i)) begin
        st_nxt.pending = 1'b0;
      end
    end
    st_nxt.dat = 32'h0;
    if (hit && !wb_we_i) begin
      unique case (idx)
        IDX_HOLD_CHSEL: st_nxt.dat = {24'h0, st_r.shadow.hold_chsel};
        IDX_ATK_DCY:    st_nxt.dat = {24'h0, st_r.shadow.atk_dcy};
        IDX_NGATE:      st_nxt.dat = {24'h0, st_r.shadow.ngate};
        IDX_GAIN_FLOOR: st_nxt.dat = {24'h0, st_r.shadow.floor};
        IDX_POL_GAIN:   st_nxt.dat = {24'h0, st_r.shadow.pol_gain};
        IDX_MIC_CTRL:   st_nxt.dat = {24'h0, st_r.shadow.mic};
        IDX_CLK_SHIFT:  st_nxt.dat = {24'h0, st_r.shadow.clk_shift};
        IDX_MUTE_STEP:  st_nxt.dat = {24'h0, st_r.shadow.mute_step};
        IDX_DEC2_CTRL:  st_nxt.dat = {24'h0, st_r.shadow.dec2_ctrl};
        IDX_DEC2_RATE:  st_nxt.dat = {24'h0, st_r.shadow.dec2_rate};
        IDX_STATUS:     st_nxt.dat = {31'h0, st_r.pending};
        default:        st_nxt.dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{shadow: BANK_RST, active: BANK_RST, pending: 1'b0,
                smp_cnt: 16'h0, dat: 32'h0, ack: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Decoded settings, registered so every output leaves a flip-flop
  bank_t a;
  logic [1:0] chsel;
  logic [1:0] ng_act;
  logic [1:0] shc;
  logic [1:0] dgc;
  always_comb begin
    a      = st_nxt.active;
    chsel  = a.hold_chsel[CHSEL_LSB +: 2];
    ng_act = a.ngate[NG_ACT_LSB +: 2];
    shc    = a.clk_shift[SHIFT_LSB +: 2];
    dgc    = a.pol_gain[DECG_LSB +: 2];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      level_ctrl_left_on <= 1'b0;
      level_ctrl_right_on <= 1'b0;
      gain_hold_cycles <= 32'h0;
      attack_cycles <= 32'h0;
      decay_cycles <= 32'h0;
      noise_gate_enable <= 1'b0;
      noise_gate_hold_gain <= 1'b0;
      noise_gate_mute <= 1'b0;
      noise_gate_threshold <= 5'h0;
      gain_floor <= 3'h0;
      left_output_invert <= 1'b0;
      right_output_invert <= 1'b0;
      dac_gain_double <= 1'b0;
      decimator_gain_mult <= 4'h1;
      stereo_average_mix <= 1'b0;
      first_decimator_channel_enables <= 2'h0;
      mic_resync_scan_clk <= 1'b0;
      digital_mic_select <= 1'b0;
      low_rate_clock_enable <= 1'b0;
      low_rate_clock_select <= 1'b0;
      analog_fixed_six_mhz_clock <= 1'b0;
      decimator_shift <= SHIFT_CODE0;
      soft_mute_enable <= 1'b0;
      soft_mute_step <= 8'h0;
      debug_dsm_right_select <= 1'b0;
      second_decimator_enable <= 1'b0;
      second_codec_master_clock_gate <= 1'b0;
      second_decimator_channel_enables <= 2'h0;
      second_decimator_channel_swap <= 1'b0;
      second_decimator_sample_rate <= 5'h0;
      dac_clock_invert <= 1'b0;
    end else begin
      wb_dat_o <= st_nxt.dat;
      wb_ack_o <= st_nxt.ack;
      level_ctrl_left_on  <= (chsel != CHSEL_OFF) && chsel[1];
      level_ctrl_right_on <= (chsel != CHSEL_OFF) && chsel[0];
      gain_hold_cycles <= doubled(a.hold_chsel[HOLD_LSB +: 4], HOLD_BASE_CYC, 1'b1);
      attack_cycles    <= doubled(a.atk_dcy[ATK_LSB +: 4], ATK_BASE_CYC, 1'b0);
      decay_cycles     <= doubled(a.atk_dcy[DCY_LSB +: 4], DCY_BASE_CYC, 1'b0);
      noise_gate_enable    <= a.ngate[NG_EN_BIT];
      // Reserved action code applies neither action
      noise_gate_hold_gain <= a.ngate[NG_EN_BIT] && !ng_act[0];
      noise_gate_mute      <= a.ngate[NG_EN_BIT] && (ng_act == NG_ACT_MUTE);
      noise_gate_threshold <= a.ngate[NG_TH_LSB +: 5];
      gain_floor <= a.floor[FLOOR_LSB +: 3];
      left_output_invert  <= a.pol_gain[LINV_BIT];
      right_output_invert <= a.pol_gain[RINV_BIT];
      dac_gain_double     <= a.pol_gain[DGAIN_BIT];
      decimator_gain_mult <= 4'h1 << dgc;
      stereo_average_mix  <= a.pol_gain[MIX_BIT];
      first_decimator_channel_enables <= a.mic[D1CH_LSB +: 2];
      mic_resync_scan_clk <= a.mic[RESYNC_BIT];
      digital_mic_select  <= a.mic[DMIC_BIT];
      low_rate_clock_enable <= a.clk_shift[LRCLK_EN_BIT];
      low_rate_clock_select <= a.clk_shift[LRCLK_SEL_BIT];
      analog_fixed_six_mhz_clock <= a.clk_shift[FIX6M_BIT];
      decimator_shift <= (shc == 2'h0) ? SHIFT_CODE0 :
                         (shc == 2'h1) ? SHIFT_CODE1 : SHIFT_CODE23;
      soft_mute_enable <= a.clk_shift[SMUTE_BIT];
      soft_mute_step   <= a.mute_step;
      debug_dsm_right_select <= a.clk_shift[DSM_SEL_BIT];
      second_decimator_enable        <= a.dec2_ctrl[D2EN_BIT];
      second_codec_master_clock_gate <= a.dec2_ctrl[MCLK2_BIT];
      second_decimator_channel_enables <= a.dec2_ctrl[D2CH_LSB +: 2];
      second_decimator_channel_swap    <= a.dec2_ctrl[D2SWAP_BIT];
      second_decimator_sample_rate <= a.dec2_rate[D2SR_LSB +: 5];
      dac_clock_invert             <= a.dec2_rate[DACINV_BIT];
    end
  end

endmodule : level_ctrl_regs

/* testbench/front_end_model.sv */
// Behavioural converter front end fed by the decoded settings.
// Assumes settings are stable levels; one fixed test sample per channel.
`timescale 1ns/1ps
module front_end_model (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        left_output_invert,
  input  wire logic        right_output_invert,
  input  wire logic        dac_gain_double,
  output logic      [15:0] left_sample_r,
  output logic      [15:0] right_sample_r
);
  // ==========================================================================
  // Output stage: invert then optional x2
  localparam logic [15:0] TEST_IN = 16'h0100;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      left_sample_r  <= 16'h0000;
      right_sample_r <= 16'h0000;
    end else begin
      left_sample_r  <= (left_output_invert ? -TEST_IN : TEST_IN) << dac_gain_double;
      right_sample_r <= (right_output_invert ? -TEST_IN : TEST_IN) << dac_gain_double;
    end
  end
endmodule : front_end_model

/* testbench/level_ctrl_regs_properties.sv */
// Checker for the register bank: bus timing and decoded-output relations.
// Assumes it is bound to level_ctrl_regs and sees only its ports.
`timescale 1ns/1ps
module level_ctrl_regs_properties
  import level_ctrl_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        noise_gate_enable,
  input wire logic        noise_gate_hold_gain,
  input wire logic        noise_gate_mute,
  input wire logic [3:0]  decimator_gain_mult,
  input wire logic [3:0]  decimator_shift,
  input wire logic [31:0] attack_cycles,
  input wire logic [31:0] decay_cycles
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // Decoded values are only meaningful once the first edge has loaded them
  logic [1:0] up_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) up_r <= 2'b00;
    else up_r <= {up_r[0], 1'b1};
  end
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_ans; endproperty
  property p_idle_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  property p_ng_hold; noise_gate_hold_gain |-> noise_gate_enable && !noise_gate_mute; endproperty
  property p_ng_mute; noise_gate_mute |-> noise_gate_enable; endproperty
  property p_shift; up_r[1] |-> decimator_shift inside {4'h7, 4'h8, 4'h9}; endproperty
  property p_mult; decimator_gain_mult inside {4'h1, 4'h2, 4'h4, 4'h8}; endproperty
  property p_atk; up_r[1] |-> attack_cycles >= ATK_BASE_CYC && attack_cycles <= (ATK_BASE_CYC << 10); endproperty
  property p_dcy; up_r[1] |-> decay_cycles == (attack_cycles << 2); endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_idle_dat: assert property (p_idle_dat) else $error("read data outside ack");
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  a_ng_hold: assert property (p_ng_hold) else $error("hold without gate");
  a_ng_mute: assert property (p_ng_mute) else $error("mute without gate");
  a_shift: assert property (p_shift) else $error("bad shift amount");
  a_mult: assert property (p_mult) else $error("bad decimator gain");
  a_atk: assert property (p_atk) else $error("attack out of range");
  a_dcy: assert property (p_dcy or (up_r[1] |-> decay_cycles[31:0] != 32'h0))
    else $error("decay zero");
endmodule : level_ctrl_regs_properties

bind level_ctrl_regs level_ctrl_regs_properties u_props (
  .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .noise_gate_enable(noise_gate_enable),
  .noise_gate_hold_gain(noise_gate_hold_gain), .noise_gate_mute(noise_gate_mute),
  .decimator_gain_mult(decimator_gain_mult), .decimator_shift(decimator_shift),
  .attack_cycles(attack_cycles), .decay_cycles(decay_cycles));

/* testbench/audio_level_control_and_record_config_tb_top.sv */
// Self-checking bench: register table, decoded settings, awkward cases.
// Assumes level_ctrl_regs on a classic Wishbone bus at 40 MHz.
`timescale 1ns/1ps
module audio_level_control_and_record_config_tb_top;
  import level_ctrl_pkg::*;
  typedef struct { logic [7:0] idx; logic [7:0] rst; logic [7:0] wv; } row_t;
  logic clk_sys = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, q;
  logic [3:0]  sel = 4'h0;
  logic        ack, l_on, r_on, ng_en, ng_hold, ng_mute, linv, rinv, dgain, mix, resync, dmic;
  logic        lr_en, lr_sel, fix6, smute, dsm, d2en, mclk2, swap2, dinv;
  logic [31:0] hold_c, atk_c, dcy_c;
  logic [4:0]  thr, sr2;
  logic [3:0]  mult, shift;
  logic [2:0]  floor_v;
  logic [1:0]  en1, en2;
  logic [7:0]  step;
  logic [15:0] l_smp, r_smp;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  row_t rows[10] = '{'{IDX_HOLD_CHSEL, 8'h00, 8'h63}, '{IDX_ATK_DCY, 8'h32, 8'hFB},
    '{IDX_NGATE, 8'h00, 8'h03}, '{IDX_GAIN_FLOOR, 8'h02, 8'h07},
    '{IDX_POL_GAIN, 8'h00, 8'hA7}, '{IDX_MIC_CTRL, 8'h40, 8'h0F},
    '{IDX_CLK_SHIFT, 8'h01, 8'hAE}, '{IDX_MUTE_STEP, 8'h0A, 8'h55},
    '{IDX_DEC2_CTRL, 8'h00, 8'h1D}, '{IDX_DEC2_RATE, 8'h00, 8'h3F}};

  level_ctrl_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .level_ctrl_left_on(l_on), .level_ctrl_right_on(r_on),
    .gain_hold_cycles(hold_c), .attack_cycles(atk_c), .decay_cycles(dcy_c),
    .noise_gate_enable(ng_en), .noise_gate_hold_gain(ng_hold), .noise_gate_mute(ng_mute),
    .noise_gate_threshold(thr), .gain_floor(floor_v), .left_output_invert(linv),
    .right_output_invert(rinv), .dac_gain_double(dgain), .decimator_gain_mult(mult),
    .stereo_average_mix(mix), .first_decimator_channel_enables(en1),
    .mic_resync_scan_clk(resync), .digital_mic_select(dmic), .low_rate_clock_enable(lr_en),
    .low_rate_clock_select(lr_sel), .analog_fixed_six_mhz_clock(fix6),
    .decimator_shift(shift), .soft_mute_enable(smute), .soft_mute_step(step),
    .debug_dsm_right_select(dsm), .second_decimator_enable(d2en),
    .second_codec_master_clock_gate(mclk2), .second_decimator_channel_enables(en2),
    .second_decimator_channel_swap(swap2), .second_decimator_sample_rate(sr2),
    .dac_clock_invert(dinv));
  front_end_model u_fe (.clk_sys(clk_sys), .resetn(resetn), .left_output_invert(linv),
    .right_output_invert(rinv), .dac_gain_double(dgain), .left_sample_r(l_smp),
    .right_sample_r(r_smp));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Hang guard: whole run needs about 25000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Classic single cycle; waits for ack, bounded by the hang guard
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= s;
    adr <= {22'h0, idx, 2'b00}; dat <= {24'h0, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb
  task do_reset();
    @(posedge clk_sys) resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : do_reset
  task wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    do_reset();
    chk({step, 7'h0, lr_en, 1'b0, floor_v, shift}, {8'h0A, 7'h0, 1'b1, 1'b0, 3'h2, 4'h8});
    chk(atk_c, ATK_BASE_CYC << 2);
    chk(dcy_c, DCY_BASE_CYC << 3);
    foreach (rows[i]) begin
      wb(1'b0, rows[i].idx, 8'h00, 4'hF);
      chk(q, {24'h0, rows[i].rst});
      wb(1'b1, rows[i].idx, rows[i].wv, 4'h1);
      wb(1'b0, rows[i].idx, 8'h00, 4'hF);
      chk(q, {24'h0, rows[i].wv});
    end
    wb(1'b0, IDX_STATUS, 8'h00, 4'hF);
    chk(q[0], 1'b1);
    chk({l_on, r_on, step}, {2'b00, 8'h0A});
    repeat (5010) @(posedge clk_sys);
    chk({l_on, r_on, hold_c}, {2'b11, HOLD_BASE_CYC << 2});
    chk(atk_c, ATK_BASE_CYC << 10);
    chk(dcy_c, DCY_BASE_CYC << 10);
    chk({ng_en, ng_hold, ng_mute, thr, floor_v}, {3'b101, 5'h00, 3'h7});
    chk({linv, rinv, dgain, mult, mix}, {3'b111, 4'h4, 1'b1});
    chk({l_smp, r_smp}, {16'hFE00, 16'hFE00});
    chk({en1, resync, dmic}, {2'b11, 2'b11});
    chk({lr_en, lr_sel, fix6, shift}, {3'b011, SHIFT_CODE23});
    chk({smute, step, dsm}, {1'b0, 8'h55, 1'b1});
    chk({d2en, mclk2, en2, swap2}, {2'b10, 2'b11, 1'b1});
    chk({sr2, dinv}, {5'h1F, 1'b1});
    // Awkward cases: unmapped place, byte lane off, all select and action codes
    wb(1'b1, 8'h26, 8'hFF, 4'h1);
    wb(1'b0, 8'h26, 8'h00, 4'hF);
    chk(q, 32'h0);
    wb(1'b1, IDX_MUTE_STEP, 8'hFF, 4'h0);
    wb(1'b0, IDX_MUTE_STEP, 8'h00, 4'hF);
    chk(q, 32'h55);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, IDX_HOLD_CHSEL, 8'(i << 5), 4'h1);
      wb(1'b1, IDX_NGATE, 8'(1 + (i << 1)), 4'h1);
      wb(1'b1, IDX_CLK_SHIFT, 8'(i << 2), 4'h1);
      repeat (5010) @(posedge clk_sys);
      chk({l_on, r_on, hold_c}, {i[1], i[0], 32'h0});
      chk({ng_hold, ng_mute}, {~i[0], i[1:0] == 2'b01});
      chk(shift, (i == 0) ? SHIFT_CODE0 : (i == 1) ? SHIFT_CODE1 : SHIFT_CODE23);
    end
    do_reset();
    wb(1'b0, IDX_ATK_DCY, 8'h00, 4'hF);
    chk(q, 32'h32);
    chk({step, mult}, {8'h0A, 4'h1});
    wrap_up();
  end
endmodule : audio_level_control_and_record_config_tb_top
